// ---- src/itsc_defs.svh ----
// Constants for the incoming trunk state controller.
// Assumes inclusion by bare name; definitions only.
`ifndef ITSC_DEFS_SVH
`define ITSC_DEFS_SVH

// Element bit positions in the state code
`define ITSC_BIT_A        0
`define ITSC_BIT_B        1
`define ITSC_BIT_C        2

// State codes
`define ITSC_ST_IDLE      3'h0
`define ITSC_ST_BYPASS    3'h1
`define ITSC_ST_LOC_FREE  3'h2
`define ITSC_ST_LOC_CHG   3'h3
`define ITSC_ST_RING      3'h4
`define ITSC_ST_TAN_FREE  3'h6
`define ITSC_ST_TAN_CHG   3'h7

// Order codes
`define ITSC_OP_RELEASE   2'h0
`define ITSC_OP_OPERATE   2'h1
`define ITSC_OP_LOAD      2'h2

// Distributor busy time
`define ITSC_BUSY_NS      25000000
`define ITSC_CLK_NS       4
`define ITSC_BUSY_CYC     (`ITSC_BUSY_NS / `ITSC_CLK_NS)
`define ITSC_CNT_W        23

`endif

// ---- src/itsc_pkg.sv ----
// Types for the incoming trunk state controller.
// Assumes itsc_defs.svh is on the include path.
package itsc_pkg;

  typedef enum logic [2:0] {
    ITSC_IDLE     = 3'b000,
    ITSC_BYPASS   = 3'b001,
    ITSC_LOC_FREE = 3'b010,
    ITSC_LOC_CHG  = 3'b011,
    ITSC_RING     = 3'b100,
    ITSC_TAN_FREE = 3'b110,
    ITSC_TAN_CHG  = 3'b111
  } itsc_state_type;

  typedef struct packed {
    logic [2:0]  elem;
    logic        busy;
    logic [22:0] cnt;
    logic        valid;
  } itsc_dist_type;

  typedef struct packed {
    logic [2:0] elem;
    logic [2:0] code;
    logic       bypass;
    logic       sense0;
    logic       sense1;
    logic       rcv_req;
    logic       seized;
    logic       legal;
  } itsc_main_type;

endpackage

// ---- src/itsc_order_dist.sv ----
// Order distributor: takes one element order, holds busy for the distributor time.
// Assumes the processor only orders while busy is low; orders while busy are dropped.
`timescale 1ns/1ps
`include "itsc_defs.svh"

module itsc_order_dist (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       order_valid_i,
  input  wire logic [1:0] order_op_i,
  input  wire logic [2:0] order_elem_i,
  output logic      [2:0] elem_o,
  output logic            busy_o,
  output logic            done_o
);

  itsc_pkg::itsc_dist_type st_r;
  itsc_pkg::itsc_dist_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (st_r.busy) begin
      if (st_r.cnt == `ITSC_CNT_W'(`ITSC_BUSY_CYC - 1)) begin
        st_nxt.busy  = 1'b0;
        st_nxt.cnt   = '0;
        st_nxt.valid = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + `ITSC_CNT_W'(1);
      end
    end else if (order_valid_i) begin
      // Elements only move on an order
      unique case (order_op_i)
        `ITSC_OP_OPERATE: st_nxt.elem = st_r.elem | order_elem_i;
        `ITSC_OP_RELEASE: st_nxt.elem = st_r.elem & ~order_elem_i;
        default:          st_nxt.elem = order_elem_i;
      endcase
      st_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign elem_o = st_r.elem;
  assign busy_o = st_r.busy;
  assign done_o = st_r.valid;

endmodule // itsc_order_dist

// ---- src/itsc_trunk.sv ----
// Incoming trunk state controller: three control elements, seven states, two sense points.
// Assumes one 250 MHz clock and a processor that obeys the distributor busy flag.
`timescale 1ns/1ps
`include "itsc_defs.svh"

module itsc_trunk (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Orders from the processor
  input  wire logic       order_valid_i,
  input  wire logic [1:0] order_op_i,
  input  wire logic [2:0] order_elem_i,
  // Line supervision levels
  input  wire logic       far_seize_i,
  input  wire logic       calling_off_hook_i,
  // State and supervision back to the processor
  output logic      [2:0] elem_o,
  output logic      [2:0] state_code_o,
  output logic            state_legal_o,
  output logic            bypass_o,
  output logic            sense0_o,
  output logic            sense1_o,
  output logic            rcv_req_o,
  output logic            dist_busy_o,
  output logic            order_done_o
);

  // State table, code = {third, second, first}
  // 00 idle, nothing operated
  // 01 bypass, first only
  // 02 talk local free, second only
  // 03 talk local charge, first and second
  // 04 ring tone, third only
  // 05 no state; held and flagged
  // 06 talk tandem free, second and third
  // 07 talk tandem charge, all three

  // Registered state and its next value
  itsc_pkg::itsc_main_type st_r;
  itsc_pkg::itsc_main_type st_nxt;
  // Element set as the distributor holds it
  logic [2:0]              elem;
  logic                    busy;
  logic                    done;
  logic [2:0]              code_bits;

  // Decoded state groups and supervision steering
  logic                    in_idle;
  logic                    in_bypass;
  logic                    watch0;
  logic                    watch1;
  logic                    in_hole;
  logic                    seize_edge;
  logic                    rcv_set;
  logic                    rcv_clr;

  // Every element change comes through the distributor; none starts here
  // Busy and done are flops inside it and pass straight out
  itsc_order_dist u_dist (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .order_valid_i (order_valid_i),
    .order_op_i    (order_op_i),
    .order_elem_i  (order_elem_i),
    .elem_o        (elem),
    .busy_o        (busy),
    .done_o        (done)
  );

  // One copy per element; element n drives code bit n
  for (genvar b = 0; b < 3; b++) begin : g_code_bit
    assign code_bits[b] = elem[b];
  end

  // Point 0 is watched in ring and talk states, point 1 only in idle
  always_comb begin
    // Defaults only; every code below sets all five
    in_idle   = 1'b0;
    in_bypass = 1'b0;
    watch0    = 1'b0;
    watch1    = 1'b0;
    in_hole   = 1'b0;
    unique case (code_bits)
      `ITSC_ST_IDLE: begin
        // All released; distant office watched
        in_idle   = 1'b1;
        in_bypass = 1'b0;
        watch0    = 1'b0;
        watch1    = 1'b1;
        in_hole   = 1'b0;
      end
      `ITSC_ST_BYPASS: begin
        // Receiver sees the bare facility
        in_idle   = 1'b0;
        in_bypass = 1'b1;
        watch0    = 1'b0;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      `ITSC_ST_LOC_FREE: begin
        // Calling line supervised on point 0
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b1;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      `ITSC_ST_LOC_CHG: begin
        // Local talk with charging
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b1;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      `ITSC_ST_RING: begin
        // Ring tone back to the caller
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b1;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      `ITSC_ST_TAN_FREE: begin
        // Tandem talk without charging
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b1;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      `ITSC_ST_TAN_CHG: begin
        // Tandem talk with charging
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b1;
        watch1    = 1'b0;
        in_hole   = 1'b0;
      end
      default: begin
        // Code 05 has no defined state
        in_idle   = 1'b0;
        in_bypass = 1'b0;
        watch0    = 1'b0;
        watch1    = 1'b0;
        in_hole   = 1'b1;
      end
    endcase
  end

  // Edge against last cycle's copy; reset clears the copy to the idle level
  assign seize_edge = far_seize_i && !st_r.seized;
  // Request rises only on a fresh seizure seen while idle
  assign rcv_set = in_idle && seize_edge;
  // Leaving idle means the processor has acted on the request
  assign rcv_clr = !in_idle;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.elem   = elem;
    st_nxt.code   = code_bits;
    // Code 05 is held as ordered, only flagged
    st_nxt.legal  = !in_hole;
    // Bridges out; clear metallic path to the receiver
    st_nxt.bypass = in_bypass;
    st_nxt.seized = far_seize_i;
    // Sense points read zero outside the states that watch them
    // Point 1 supervises the distant office
    st_nxt.sense1 = watch1 && far_seize_i;
    // Point 0 supervises the calling line
    st_nxt.sense0 = watch0 && calling_off_hook_i;
    // Set wins over clear, though both cannot fall in one cycle
    if (rcv_set) begin
      st_nxt.rcv_req = 1'b1;
    end else if (rcv_clr) begin
      st_nxt.rcv_req = 1'b0;
    end
  end

  // Reset releases every element and leaves the code legal
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.legal <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are all flops of the state copy or of the distributor
  assign elem_o        = st_r.elem;
  assign state_code_o  = st_r.code;
  assign state_legal_o = st_r.legal;
  assign bypass_o      = st_r.bypass;
  assign sense0_o      = st_r.sense0;
  assign sense1_o      = st_r.sense1;
  assign rcv_req_o     = st_r.rcv_req;
  assign dist_busy_o   = busy;
  // Done pulse marks the end of the busy time
  assign order_done_o  = done;

endmodule // itsc_trunk

// ---- verif/itsc_trunk_properties.sv ----
// Port checker for the trunk controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module itsc_trunk_props (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       order_valid_i,
  input wire logic       far_seize_i,
  input wire logic       calling_off_hook_i,
  input wire logic [2:0] elem_o,
  input wire logic [2:0] state_code_o,
  input wire logic       state_legal_o,
  input wire logic       bypass_o,
  input wire logic       sense0_o,
  input wire logic       sense1_o,
  input wire logic       rcv_req_o,
  input wire logic       dist_busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    order_valid_i && !dist_busy_o;
  endsequence
  a_code_elem: assert property (state_code_o == elem_o)
    else $error("code differs from elements");
  a_bypass_code: assert property (bypass_o == (state_code_o == 3'h1))
    else $error("bypass flag wrong");
  a_legal_code: assert property (state_legal_o == (state_code_o != 3'h5))
    else $error("legal flag wrong");
  a_busy_holds: assert property (s_take |=> dist_busy_o [*8])
    else $error("busy too short");
  a_no_self: assert property ($changed(elem_o) |-> $past(order_valid_i, 2))
    else $error("elements moved alone");
  a_sense1_cause: assert property (sense1_o |-> $past(far_seize_i))
    else $error("sense 1 without seizure");
  a_sense0_cause: assert property (sense0_o |-> $past(calling_off_hook_i))
    else $error("sense 0 without line");
  a_rcv_idle: assert property ($rose(rcv_req_o) |-> state_code_o == 3'h0)
    else $error("receiver asked off idle");
endmodule // itsc_trunk_props

bind itsc_trunk itsc_trunk_props itsc_trunk_props_inst (
  .clock_i(clock_i), .rst_i(rst_i), .order_valid_i(order_valid_i),
  .far_seize_i(far_seize_i), .calling_off_hook_i(calling_off_hook_i),
  .elem_o(elem_o), .state_code_o(state_code_o), .state_legal_o(state_legal_o),
  .bypass_o(bypass_o), .sense0_o(sense0_o), .sense1_o(sense1_o),
  .rcv_req_o(rcv_req_o), .dist_busy_o(dist_busy_o));

// ---- verif/itsc_cpu_model.sv ----
// Processor model: one element order per bench request.
// Assumes go_i is a one-cycle pulse; a request seen while busy is high is dropped, not held.
`timescale 1ns/1ps
module itsc_cpu_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [1:0] op_i,
  input  wire logic [2:0] mask_i,
  input  wire logic       busy_i,
  output logic            order_valid_o = 1'b0,
  output logic      [1:0] order_op_o = 2'h0,
  output logic      [2:0] order_elem_o = 3'h0
);
  // Never orders unasked, so the trunk cannot drift
  always @(posedge clock_i) begin
    order_valid_o <= go_i && !busy_i && !rst_i;
    order_op_o <= op_i;
    order_elem_o <= mask_i;
  end
endmodule // itsc_cpu_model

// ---- verif/itsc_trunk_tb.sv ----
// Self-checking bench for the trunk controller.
// Assumes the busy time is long, so every order but the last follows a reset; the last is sent while busy.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module itsc_trunk_tb;
  logic       clock_i = 0;
  logic       rst_i = 1;
  logic       go = 0;
  logic       seize = 0;
  logic       hook = 0;
  logic [1:0] op = 0;
  logic [1:0] o;
  logic [2:0] mask = 0;
  logic [2:0] m, e, elem, code;
  logic       ov, legal, byp, s0, s1, rcv, busy;
  logic [1:0] oop;
  logic [2:0] oel;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         seed = 32'h6fa80945;
  always #2 clock_i = ~clock_i;
  itsc_cpu_model itsc_cpu_model_inst (.clock_i(clock_i), .rst_i(rst_i), .go_i(go),
    .op_i(op), .mask_i(mask), .busy_i(busy), .order_valid_o(ov),
    .order_op_o(oop), .order_elem_o(oel));
  itsc_trunk itsc_trunk_inst (.clock_i(clock_i), .rst_i(rst_i), .order_valid_i(ov),
    .order_op_i(oop), .order_elem_i(oel), .far_seize_i(seize),
    .calling_off_hook_i(hook), .elem_o(elem), .state_code_o(code),
    .state_legal_o(legal), .bypass_o(byp), .sense0_o(s0), .sense1_o(s1),
    .rcv_req_o(rcv), .dist_busy_o(busy), .order_done_o());
  function automatic logic [2:0] f_code(input logic [1:0] c, input logic [2:0] k);
    return (c == 2'h0) ? 3'h0 : k;
  endfunction
  task automatic t_reset(input logic h);
    @(posedge clock_i);
    rst_i <= 1;
    hook <= h;
    repeat (5) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic t_order(input logic [1:0] c, input logic [2:0] k);
    @(posedge clock_i);
    go <= 1;
    op <= c;
    mask <= k;
    @(posedge clock_i);
    go <= 0;
    repeat (5) @(posedge clock_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 40; i++) begin
      m = (i < 8) ? i[2:0] : 3'($random(seed));
      o = (i < 8) ? 2'h2 : 2'($random(seed));
      e = f_code(o, m);
      t_reset(1'($random(seed)));
      `CHK(code, 3'h0)
      `CHK(legal, 1'b1)
      t_order(o, m);
      `CHK(code, e)
      `CHK(busy, 1'b1)
      `CHK(elem, e)
      `CHK(byp, e == 3'h1)
      `CHK(legal, e != 3'h5)
      `CHK(s0, hook & (e inside {3'h2, 3'h3, 3'h4, 3'h6, 3'h7}))
    end
    t_reset(1'b0);
    seize <= 1;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(s1, 1'b1)
    `CHK(rcv, 1'b1)
    t_order(2'h1, 3'h1);
    `CHK(byp, 1'b1)
    `CHK(rcv, 1'b0)
    `CHK(s1, 1'b0)
    t_order(2'h2, 3'h4);
    `CHK(code, 3'h1)
    `CHK(busy, 1'b1)
    test_done();
  end
endmodule // itsc_trunk_tb
